// ==== design/psgl_pkg.sv ====
// Constants and carrier types for the shadow and global load block
package psgl_pkg;
  localparam int VAL_W = 16;
  localparam int HR_W = 8;
  localparam int SH_W = VAL_W + HR_W;
  localparam int NCMP = 4;
  localparam int ADDR_W = 8;

  localparam logic [7:0] OFF_TB_CTRL = 8'h00;
  localparam logic [7:0] OFF_PHASE = 8'h04;
  localparam logic [7:0] OFF_PERIOD = 8'h08;
  localparam logic [7:0] OFF_CMP_BASE = 8'h0C;
  localparam logic [7:0] OFF_GLD_SELECT = 8'h1C;
  localparam logic [7:0] OFF_GLD_CONTROL = 8'h20;
  localparam logic [7:0] OFF_ONE_SHOT = 8'h24;
  localparam logic [7:0] OFF_LINK_SELECT = 8'h28;
  localparam logic [7:0] OFF_COUNTER = 8'h2C;
  localparam logic [7:0] OFF_PERIOD_ACT = 8'h30;
  localparam logic [7:0] OFF_CMP_ACT_BASE = 8'h34;

  localparam int TB_PHASE_EN = 0;
  localparam int TB_PRD_SYNC = 1;
  localparam int TB_CMP_MODE_LSB = 2;
  localparam int GC_ENABLE = 0;
  localparam int GC_MODE_LSB = 1;
  localparam int GC_ONE_SHOT_MODE = 4;
  localparam int OS_LATCH = 0;
  localparam int SEL_PERIOD = 0;
  localparam int SEL_CMP_LSB = 1;
  localparam int SEL_ONE_SHOT = 5;

  localparam logic [VAL_W-1:0] RST_PERIOD = 16'hFFFF;
  localparam logic [VAL_W-1:0] RST_COUNTER = 16'h0000;

  // Global load event choices
  localparam logic [2:0] GM_ZERO = 3'h0;
  localparam logic [2:0] GM_PERIOD = 3'h1;
  localparam logic [2:0] GM_ZERO_PERIOD = 3'h2;
  localparam logic [2:0] GM_SYNC = 3'h3;
  localparam logic [2:0] GM_SYNC_ZERO = 3'h4;
  localparam logic [2:0] GM_SYNC_PERIOD = 3'h5;

  // Link targets
  localparam logic [2:0] LT_PERIOD = 3'h0;
  localparam logic [2:0] LT_CMP_A = 3'h1;
  localparam logic [2:0] LT_ONE_SHOT = 3'h5;

  typedef logic [NCMP-1:0][SH_W-1:0] psgl_cmp_t;

  typedef struct packed {
    logic valid;
    logic [2:0] target;
    logic [SH_W-1:0] data;
  } psgl_link_s;

  typedef struct packed {
    logic [VAL_W-1:0] ctr;
    logic [SH_W-1:0] prdSh;
    logic [SH_W-1:0] prdAct;
    psgl_cmp_t cmpSh;
    psgl_cmp_t cmpAct;
    logic [VAL_W-1:0] phase;
    logic phsEn;
    logic prdSync;
    logic [NCMP-1:0] cmpMode;
    logic [NCMP:0] gldSel;
    logic gldEn;
    logic [2:0] global_load_event_select;
    logic one_shot_mode_enable;
    logic oshtLatch;
    logic [NCMP+1:0] linkSel;
    logic [31:0] rdData;
  } psgl_state_s;
endpackage

// ==== design/psgl_shadow_load.sv ====
// Time base with shadow, local, linked and global one-shot loading of period and compares
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
module psgl_shadow_load (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [psgl_pkg::ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  input wire logic syncInputPulse,
  input wire psgl_pkg::psgl_link_s linkIn,
  output psgl_pkg::psgl_link_s linkOut,
  output logic [psgl_pkg::VAL_W-1:0] timeBaseCounter,
  output logic cntZero,
  output logic cntPeriod,
  output logic [psgl_pkg::SH_W-1:0] activePeriod,
  output psgl_pkg::psgl_cmp_t activeCompare,
  output logic oneShotLatch
);
  psgl_pkg::psgl_state_s s_r;
  psgl_pkg::psgl_state_s s_nxt;
  logic globalEvt;
  logic gldFire;
  logic [psgl_pkg::NCMP:0] localLoad;
  logic [psgl_pkg::NCMP:0] doLoad;
  logic linkHit;
  logic swLatchSet;
  logic linkLatchSet;

  assign timeBaseCounter = s_r.ctr;
  assign activePeriod = s_r.prdAct;
  assign activeCompare = s_r.cmpAct;
  assign oneShotLatch = s_r.oshtLatch;
  assign regRdData = s_r.rdData;
  assign cntZero = (s_r.ctr == psgl_pkg::RST_COUNTER);
  assign cntPeriod = (s_r.ctr == s_r.prdAct[psgl_pkg::VAL_W-1:0]);

  // Linked writes go out in the same cycle as the local write
  always_comb begin
    linkOut = '0;
    if (regWrite) begin
      if (regAddr == psgl_pkg::OFF_PERIOD) begin
        linkOut.valid = 1'b1;
        linkOut.target = psgl_pkg::LT_PERIOD;
      end else if (regAddr >= psgl_pkg::OFF_CMP_BASE && regAddr < psgl_pkg::OFF_GLD_SELECT) begin
        linkOut.valid = 1'b1;
        linkOut.target = 3'((regAddr - psgl_pkg::OFF_CMP_BASE) >> 2) + psgl_pkg::LT_CMP_A;
      end else if (regAddr == psgl_pkg::OFF_ONE_SHOT) begin
        linkOut.valid = 1'b1;
        linkOut.target = psgl_pkg::LT_ONE_SHOT;
      end
      linkOut.data = regWrData[psgl_pkg::SH_W-1:0];
    end
  end

  // Global event selection
  always_comb begin
    unique case (s_r.global_load_event_select)
      psgl_pkg::GM_ZERO: globalEvt = cntZero;
      psgl_pkg::GM_PERIOD: globalEvt = cntPeriod;
      psgl_pkg::GM_ZERO_PERIOD: globalEvt = cntZero | cntPeriod;
      psgl_pkg::GM_SYNC: globalEvt = syncInputPulse;
      psgl_pkg::GM_SYNC_ZERO: globalEvt = syncInputPulse | cntZero;
      psgl_pkg::GM_SYNC_PERIOD: globalEvt = syncInputPulse | cntPeriod;
      default: globalEvt = 1'b0;
    endcase
  end

  assign gldFire = s_r.gldEn & globalEvt & (~s_r.one_shot_mode_enable | s_r.oshtLatch);
  assign linkHit = linkIn.valid & s_r.linkSel[linkIn.target];
  assign swLatchSet = regWrite & (regAddr == psgl_pkg::OFF_ONE_SHOT) & regWrData[psgl_pkg::OS_LATCH];
  assign linkLatchSet = linkHit & (linkIn.target == psgl_pkg::LT_ONE_SHOT) & linkIn.data[psgl_pkg::OS_LATCH];

  always_comb begin
    // sync adds a load for period and compares
    localLoad[0] = cntZero | (s_r.prdSync & syncInputPulse);
    for (int i = 0; i < psgl_pkg::NCMP; i++) begin
      localLoad[i+1] = (s_r.cmpMode[i] ? cntPeriod : cntZero) | (s_r.prdSync & syncInputPulse);
    end
    // only selected registers follow the global event
    // selected registers share the global event
    for (int i = 0; i <= psgl_pkg::NCMP; i++) begin
      doLoad[i] = (s_r.gldEn & s_r.gldSel[i]) ? gldFire : localLoad[i];
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdData = '0;
    if (syncInputPulse && s_r.phsEn) begin
      s_nxt.ctr = s_r.phase;
    end else if (cntPeriod) begin
      s_nxt.ctr = psgl_pkg::RST_COUNTER;
    end else begin
      // above the period the counter runs on and wraps
      s_nxt.ctr = s_r.ctr + 16'h0001;
    end
    // transfer shadow to active only on a load event
    if (doLoad[0]) begin
      s_nxt.prdAct = s_r.prdSh;
    end
    for (int i = 0; i < psgl_pkg::NCMP; i++) begin
      if (doLoad[i+1]) begin
        s_nxt.cmpAct[i] = s_r.cmpSh[i];
      end
    end
    if (linkHit) begin
      if (linkIn.target == psgl_pkg::LT_PERIOD) begin
        s_nxt.prdSh = linkIn.data;
      end else if (linkIn.target >= psgl_pkg::LT_CMP_A && linkIn.target < psgl_pkg::LT_ONE_SHOT) begin
        s_nxt.cmpSh[2'(linkIn.target - psgl_pkg::LT_CMP_A)] = linkIn.data;
      end
    end
    // latch clears after its one transfer
    // later events find the latch clear
    if (gldFire && s_r.one_shot_mode_enable) begin
      s_nxt.oshtLatch = 1'b0;
    end
    // Set beats the self-clear so a late software set is never lost
    if (swLatchSet || linkLatchSet) begin
      s_nxt.oshtLatch = 1'b1;
    end
    if (regWrite) begin
      unique case (regAddr)
        psgl_pkg::OFF_TB_CTRL: begin
          s_nxt.phsEn = regWrData[psgl_pkg::TB_PHASE_EN];
          s_nxt.prdSync = regWrData[psgl_pkg::TB_PRD_SYNC];
          s_nxt.cmpMode = regWrData[psgl_pkg::TB_CMP_MODE_LSB +: psgl_pkg::NCMP];
        end
        psgl_pkg::OFF_PHASE: s_nxt.phase = regWrData[psgl_pkg::VAL_W-1:0];
        psgl_pkg::OFF_PERIOD: s_nxt.prdSh = regWrData[psgl_pkg::SH_W-1:0];
        psgl_pkg::OFF_GLD_SELECT: s_nxt.gldSel = regWrData[psgl_pkg::NCMP:0];
        psgl_pkg::OFF_GLD_CONTROL: begin
          s_nxt.gldEn = regWrData[psgl_pkg::GC_ENABLE];
          s_nxt.global_load_event_select = regWrData[psgl_pkg::GC_MODE_LSB +: 3];
          s_nxt.one_shot_mode_enable = regWrData[psgl_pkg::GC_ONE_SHOT_MODE];
        end
        psgl_pkg::OFF_LINK_SELECT: s_nxt.linkSel = regWrData[psgl_pkg::NCMP+1:0];
        default: begin
          if (regAddr >= psgl_pkg::OFF_CMP_BASE && regAddr < psgl_pkg::OFF_GLD_SELECT) begin
            s_nxt.cmpSh[2'((regAddr - psgl_pkg::OFF_CMP_BASE) >> 2)] = regWrData[psgl_pkg::SH_W-1:0];
          end
        end
      endcase
    end
    if (regRead) begin
      unique case (regAddr)
        psgl_pkg::OFF_TB_CTRL: begin
          s_nxt.rdData[psgl_pkg::TB_PHASE_EN] = s_r.phsEn;
          s_nxt.rdData[psgl_pkg::TB_PRD_SYNC] = s_r.prdSync;
          s_nxt.rdData[psgl_pkg::TB_CMP_MODE_LSB +: psgl_pkg::NCMP] = s_r.cmpMode;
        end
        psgl_pkg::OFF_PHASE: s_nxt.rdData[psgl_pkg::VAL_W-1:0] = s_r.phase;
        psgl_pkg::OFF_PERIOD: s_nxt.rdData[psgl_pkg::SH_W-1:0] = s_r.prdSh;
        psgl_pkg::OFF_GLD_SELECT: s_nxt.rdData[psgl_pkg::NCMP:0] = s_r.gldSel;
        psgl_pkg::OFF_GLD_CONTROL: begin
          s_nxt.rdData[psgl_pkg::GC_ENABLE] = s_r.gldEn;
          s_nxt.rdData[psgl_pkg::GC_MODE_LSB +: 3] = s_r.global_load_event_select;
          s_nxt.rdData[psgl_pkg::GC_ONE_SHOT_MODE] = s_r.one_shot_mode_enable;
        end
        psgl_pkg::OFF_ONE_SHOT: s_nxt.rdData[psgl_pkg::OS_LATCH] = s_r.oshtLatch;
        psgl_pkg::OFF_LINK_SELECT: s_nxt.rdData[psgl_pkg::NCMP+1:0] = s_r.linkSel;
        psgl_pkg::OFF_COUNTER: s_nxt.rdData[psgl_pkg::VAL_W-1:0] = s_r.ctr;
        psgl_pkg::OFF_PERIOD_ACT: s_nxt.rdData[psgl_pkg::SH_W-1:0] = s_r.prdAct;
        default: begin
          if (regAddr >= psgl_pkg::OFF_CMP_BASE && regAddr < psgl_pkg::OFF_GLD_SELECT) begin
            s_nxt.rdData[psgl_pkg::SH_W-1:0] = s_r.cmpSh[2'((regAddr - psgl_pkg::OFF_CMP_BASE) >> 2)];
          end else if (regAddr >= psgl_pkg::OFF_CMP_ACT_BASE && regAddr < 8'h44) begin
            s_nxt.rdData[psgl_pkg::SH_W-1:0] = s_r.cmpAct[2'((regAddr - psgl_pkg::OFF_CMP_ACT_BASE) >> 2)];
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_r <= '0;
      s_r.prdSh <= {{psgl_pkg::HR_W{1'b0}}, psgl_pkg::RST_PERIOD};
      s_r.prdAct <= {{psgl_pkg::HR_W{1'b0}}, psgl_pkg::RST_PERIOD};
    end else begin
      s_r <= s_nxt;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_phase_on_sync: assert property (
    syncInputPulse && s_r.phsEn |=> s_r.ctr == $past(s_r.phase))
    else $error("counter missed phase load on sync");
  a_shadow_holds: assert property (
    !doLoad[0] |=> s_r.prdAct == $past(s_r.prdAct))
    else $error("active period changed without load event");
  a_period_at_zero: assert property (
    cntZero && !(s_r.gldEn && s_r.gldSel[psgl_pkg::SEL_PERIOD]) |=> s_r.prdAct == $past(s_r.prdSh))
    else $error("period shadow not loaded at zero");
  a_sync_loads_cmp: assert property (
    syncInputPulse && s_r.prdSync && !(s_r.gldEn && s_r.gldSel[psgl_pkg::SEL_CMP_LSB])
      |=> s_r.cmpAct[0] == $past(s_r.cmpSh[0]))
    else $error("compare not loaded on sync");
  a_count_past_period: assert property (
    s_r.ctr > s_r.prdAct[psgl_pkg::VAL_W-1:0] && !(syncInputPulse && s_r.phsEn)
      |=> s_r.ctr == 16'($past(s_r.ctr) + 16'h0001))
    else $error("counter above period did not keep counting");
  a_link_write: assert property (
    linkIn.valid && linkIn.target == psgl_pkg::LT_PERIOD && s_r.linkSel[psgl_pkg::SEL_PERIOD]
      && !(regWrite && regAddr == psgl_pkg::OFF_PERIOD) |=> s_r.prdSh == $past(linkIn.data))
    else $error("linked period write lost");
  a_global_only: assert property (
    s_r.gldEn && s_r.gldSel[psgl_pkg::SEL_CMP_LSB] && !gldFire |=> $stable(s_r.cmpAct[0]))
    else $error("selected compare loaded outside global event");
  a_oneshot_block: assert property (
    s_r.gldEn && s_r.one_shot_mode_enable && !s_r.oshtLatch |-> !gldFire)
    else $error("global load passed while one-shot latch clear");
  a_oneshot_once: assert property (
    gldFire && s_r.one_shot_mode_enable && !swLatchSet && !linkLatchSet |=> !s_r.oshtLatch ##1 !gldFire [*1])
    else $error("one-shot latch did not clear after transfer");
  a_link_latch: assert property (
    linkLatchSet |=> s_r.oshtLatch)
    else $error("linked latch set not taken");

  // Register port: shadows take writes, reads answer one cycle later and only then
  a_wr_period_shadow: assert property (
    regWrite && regAddr == psgl_pkg::OFF_PERIOD |=> s_r.prdSh == $past(regWrData[psgl_pkg::SH_W-1:0]))
    else $error("period shadow missed a write");
  a_wr_phase: assert property (
    regWrite && regAddr == psgl_pkg::OFF_PHASE |=> s_r.phase == $past(regWrData[psgl_pkg::VAL_W-1:0]))
    else $error("phase register missed a write");
  a_rd_shadow: assert property (
    regRead && regAddr == psgl_pkg::OFF_PERIOD |=> regRdData[psgl_pkg::SH_W-1:0] == $past(s_r.prdSh))
    else $error("period shadow read back wrong");
  a_rd_active: assert property (
    regRead && regAddr == psgl_pkg::OFF_PERIOD_ACT |=> regRdData[psgl_pkg::SH_W-1:0] == $past(s_r.prdAct))
    else $error("active period read back wrong");
  a_rd_latch: assert property (
    regRead && regAddr == psgl_pkg::OFF_ONE_SHOT |=> regRdData[psgl_pkg::OS_LATCH] == $past(s_r.oshtLatch))
    else $error("one-shot latch read back wrong");
  a_rd_idle_zero: assert property (
    !regRead |=> regRdData == 32'h00000000)
    else $error("read data left standing without a read");

  // Outgoing linked copy mirrors the local write in the same cycle
  a_link_out_period: assert property (
    regWrite && regAddr == psgl_pkg::OFF_PERIOD
      |-> linkOut.valid && linkOut.target == psgl_pkg::LT_PERIOD
        && linkOut.data == regWrData[psgl_pkg::SH_W-1:0])
    else $error("period write not mirrored on the link");
  a_link_out_idle: assert property (
    !regWrite |-> !linkOut.valid)
    else $error("link copy sent without a write");

  // Incoming linked writes obey the per-register link enables
  a_link_ignored: assert property (
    linkIn.valid && linkIn.target == psgl_pkg::LT_PERIOD && !s_r.linkSel[psgl_pkg::SEL_PERIOD]
      && !(regWrite && regAddr == psgl_pkg::OFF_PERIOD) |=> $stable(s_r.prdSh))
    else $error("unlinked period took a linked write");
  a_link_cmp: assert property (
    linkIn.valid && linkIn.target == psgl_pkg::LT_CMP_A && s_r.linkSel[psgl_pkg::SEL_CMP_LSB]
      && !(regWrite && regAddr == psgl_pkg::OFF_CMP_BASE) |=> s_r.cmpSh[0] == $past(linkIn.data))
    else $error("linked compare write lost");

  // Time base around the period and the sync pulse
  a_wrap_at_period: assert property (
    cntPeriod && !(syncInputPulse && s_r.phsEn) |=> s_r.ctr == psgl_pkg::RST_COUNTER)
    else $error("counter did not return to zero at period");
  a_phase_off: assert property (
    syncInputPulse && !s_r.phsEn && !cntPeriod |=> s_r.ctr == 16'($past(s_r.ctr) + 16'h0001))
    else $error("counter jumped on sync with phase load off");
  a_prdsync_off: assert property (
    syncInputPulse && !s_r.prdSync && !cntZero && !(s_r.gldEn && s_r.gldSel[psgl_pkg::SEL_PERIOD])
      |=> $stable(s_r.prdAct))
    else $error("period loaded on sync with load on sync off");

  // Local events for registers that global load leaves alone
  a_cmp_at_zero: assert property (
    cntZero && !s_r.cmpMode[0] && !(s_r.gldEn && s_r.gldSel[psgl_pkg::SEL_CMP_LSB])
      |=> s_r.cmpAct[0] == $past(s_r.cmpSh[0]))
    else $error("compare missed its local zero load");
  a_cmp_at_period: assert property (
    cntPeriod && s_r.cmpMode[0] && !(s_r.gldEn && s_r.gldSel[psgl_pkg::SEL_CMP_LSB])
      |=> s_r.cmpAct[0] == $past(s_r.cmpSh[0]))
    else $error("compare missed its local period load");

  // Global event decode and the selected registers
  a_mode_zero: assert property (
    s_r.global_load_event_select == psgl_pkg::GM_ZERO |-> globalEvt == cntZero)
    else $error("zero global event decoded wrong");
  a_mode_period: assert property (
    s_r.global_load_event_select == psgl_pkg::GM_PERIOD |-> globalEvt == cntPeriod)
    else $error("period global event decoded wrong");
  a_mode_sync: assert property (
    s_r.global_load_event_select == psgl_pkg::GM_SYNC |-> globalEvt == syncInputPulse)
    else $error("sync global event decoded wrong");
  a_mode_none: assert property (
    s_r.global_load_event_select > psgl_pkg::GM_SYNC_PERIOD |-> !globalEvt)
    else $error("unused global mode produced an event");
  a_global_free: assert property (
    s_r.gldEn && !s_r.one_shot_mode_enable && globalEvt |-> gldFire)
    else $error("global event dropped outside one-shot mode");
  a_global_selected: assert property (
    s_r.gldEn && s_r.gldSel[psgl_pkg::SEL_PERIOD] && gldFire |=> s_r.prdAct == $past(s_r.prdSh))
    else $error("selected period missed the global event");
  a_global_period_hold: assert property (
    s_r.gldEn && s_r.gldSel[psgl_pkg::SEL_PERIOD] && !gldFire |=> $stable(s_r.prdAct))
    else $error("selected period loaded outside global event");

  // One-shot latch: set by software, held until its single transfer
  a_latch_sw_set: assert property (
    swLatchSet |=> s_r.oshtLatch)
    else $error("software latch set not taken");
  a_latch_holds: assert property (
    s_r.oshtLatch && !gldFire |=> s_r.oshtLatch)
    else $error("one-shot latch dropped without a transfer");

  c_phase_sync: cover property (syncInputPulse && s_r.phsEn ##1 cntZero [*1]);
  c_oneshot_fire: cover property (s_r.oshtLatch && gldFire && s_r.one_shot_mode_enable);
  c_link_hit: cover property (linkHit && linkIn.target == psgl_pkg::LT_PERIOD);
  c_sync_load: cover property (syncInputPulse && s_r.prdSync);
  c_link_latch: cover property (linkLatchSet);
endmodule

// ==== testbench/psgl_link_partner.sv ====
// Sync source and leading linked module as seen by the follower
`timescale 1ns/1ps
module psgl_link_partner (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic goSync,
  input wire logic goLink,
  input wire logic [2:0] goTgt,
  input wire logic [psgl_pkg::SH_W-1:0] goData,
  output logic syncInputPulse,
  output psgl_pkg::psgl_link_s linkIn
);
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      syncInputPulse <= 1'b0;
      linkIn <= '0;
    end else begin
      syncInputPulse <= goSync;
      linkIn.valid <= goLink;
      // Off-pulse fields are scrambled so a late reader sees junk
      linkIn.target <= goLink ? goTgt : ~linkIn.target;
      linkIn.data <= goLink ? goData : ~linkIn.data;
    end
  end
endmodule

// ==== testbench/psgl_shadow_load_tb.sv ====
// Self-checking bench for the shadow and global load block
`timescale 1ns/1ps
module psgl_shadow_load_tb;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regRdData;
  logic goSync = 1'b0;
  logic goLink = 1'b0;
  logic [2:0] goTgt = 3'h0;
  logic [23:0] goData = 24'h0;
  logic syncInputPulse;
  psgl_pkg::psgl_link_s linkIn;
  psgl_pkg::psgl_link_s linkOut;
  logic [15:0] cnt;
  logic cntZero;
  logic cntPeriod;
  logic [23:0] actPrd;
  psgl_pkg::psgl_cmp_t actCmp;
  logic oneShotLatch;
  int n_errors = 0;
  int checked = 0;

  always #2.5 mclk = ~mclk;

  psgl_link_partner peer (.mclk(mclk), .reset_n(reset_n), .goSync(goSync), .goLink(goLink),
    .goTgt(goTgt), .goData(goData), .syncInputPulse(syncInputPulse), .linkIn(linkIn));
  psgl_shadow_load dut (.mclk(mclk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .syncInputPulse(syncInputPulse),
    .linkIn(linkIn), .linkOut(linkOut), .timeBaseCounter(cnt), .cntZero(cntZero),
    .cntPeriod(cntPeriod), .activePeriod(actPrd), .activeCompare(actCmp), .oneShotLatch(oneShotLatch));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1;
    chk(regRdData, e);
  endtask

  // Pulse lands at the device one edge after the request; returns with its effect settled
  task automatic sync_pulse();
    @(posedge mclk);
    goSync <= 1'b1;
    @(posedge mclk);
    goSync <= 1'b0;
    @(posedge mclk);
    #1;
  endtask

  task automatic link_send(input logic [2:0] t, input logic [23:0] d);
    @(posedge mclk);
    goLink <= 1'b1;
    goTgt <= t;
    goData <= d;
    @(posedge mclk);
    goLink <= 1'b0;
    @(posedge mclk);
    #1;
  endtask

  task automatic t_reset();
    chk(actPrd, 32'h00FFFF);
    wr(psgl_pkg::OFF_PERIOD_ACT, 32'h1234);
    rdchk(psgl_pkg::OFF_PERIOD_ACT, 32'h00FFFF);
    rdchk(8'hFC, 32'h0);
  endtask

  task automatic t_phase();
    wr(psgl_pkg::OFF_TB_CTRL, 32'h1);
    wr(psgl_pkg::OFF_PHASE, 32'hFFFF);
    wr(psgl_pkg::OFF_PERIOD, 32'h10);
    wr(psgl_pkg::OFF_CMP_BASE, 32'h5);
    chk(actPrd, 32'h00FFFF);
    sync_pulse();
    chk(cnt, 32'hFFFF);
    chk(cntPeriod, 32'h1);
    @(posedge mclk);
    #1;
    chk(cnt, 32'h0);
    chk(cntZero, 32'h1);
    @(posedge mclk);
    #1;
    chk(actPrd, 32'h10);
    chk(actCmp[0], 32'h5);
  endtask

  task automatic t_overrun();
    wr(psgl_pkg::OFF_PHASE, 32'h20);
    sync_pulse();
    chk(cnt, 32'h20);
    repeat (3) @(posedge mclk);
    #1;
    chk(cnt, 32'h23);
  endtask

  task automatic t_sync_load();
    wr(psgl_pkg::OFF_TB_CTRL, 32'h3);
    wr(psgl_pkg::OFF_PERIOD, 32'h30);
    wr(psgl_pkg::OFF_CMP_BASE + 8'h04, 32'h7);
    sync_pulse();
    chk(actPrd, 32'h30);
    chk(actCmp[1], 32'h7);
  endtask

  task automatic t_link();
    wr(psgl_pkg::OFF_LINK_SELECT, 32'h3F);
    for (int t = 0; t < 5; t++) begin
      link_send(3'(t), 24'(32'h30 + t));
      rdchk(psgl_pkg::OFF_PERIOD + 8'(4 * t), 32'h30 + t);
    end
    @(posedge mclk);
    regAddr <= psgl_pkg::OFF_PERIOD;
    regWrData <= 32'h30;
    regWrite <= 1'b1;
    #1;
    chk(linkOut.valid, 32'h1);
    chk(linkOut.target, psgl_pkg::LT_PERIOD);
    chk(linkOut.data, 32'h30);
    @(posedge mclk);
    regWrite <= 1'b0;
    wr(psgl_pkg::OFF_LINK_SELECT, 32'h0);
    link_send(psgl_pkg::LT_PERIOD, 24'h999);
    rdchk(psgl_pkg::OFF_PERIOD, 32'h30);
  endtask

  task automatic t_global();
    wr(psgl_pkg::OFF_TB_CTRL, 32'h0);
    wr(psgl_pkg::OFF_CMP_BASE, 32'h9);
    wr(psgl_pkg::OFF_GLD_CONTROL, 32'h17);
    wr(psgl_pkg::OFF_GLD_SELECT, 32'h1);
    wr(psgl_pkg::OFF_PERIOD, 32'h40);
    repeat (120) @(posedge mclk);
    #1;
    chk(actPrd, 32'h30);
    chk(actCmp[0], 32'h9);
    sync_pulse();
    chk(actPrd, 32'h30);
    wr(psgl_pkg::OFF_LINK_SELECT, 32'h20);
    link_send(psgl_pkg::LT_ONE_SHOT, 24'h1);
    chk(oneShotLatch, 32'h1);
    sync_pulse();
    chk(actPrd, 32'h40);
    chk(oneShotLatch, 32'h0);
    wr(psgl_pkg::OFF_PERIOD, 32'h50);
    sync_pulse();
    chk(actPrd, 32'h40);
    wr(psgl_pkg::OFF_ONE_SHOT, 32'h1);
    sync_pulse();
    chk(actPrd, 32'h50);
    // Free global load on period match, then an event code that never fires
    wr(psgl_pkg::OFF_GLD_CONTROL, 32'h03);
    wr(psgl_pkg::OFF_PERIOD, 32'h60);
    repeat (100) @(posedge mclk);
    #1;
    chk(actPrd, 32'h60);
    wr(psgl_pkg::OFF_GLD_CONTROL, 32'h0D);
    wr(psgl_pkg::OFF_PERIOD, 32'h70);
    repeat (100) @(posedge mclk);
    #1;
    chk(actPrd, 32'h60);
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    #1;
    t_reset();
    t_phase();
    t_overrun();
    t_sync_load();
    t_link();
    t_global();
    wrap_up();
  end

  // A hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    wrap_up();
  end
endmodule
